// ==== src/pmbus_target_onoff_control.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_onoff_defs.vh"
// ==========================================================
module pmbus_target_onoff_control #(
   parameter [7:0] TURN_ON_SRC_NV = `TURN_ON_SRC_RST
) (
   input wire clock,
   input wire rst_b,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire enable_pin,
   input wire bias_good,
   input wire [4:0] strap_level,
   output reg converter_on,
   output reg [1:0] margin_sel,
   output reg ignore_faults,
   output wire forced_continuous_conduction,
   output wire [6:0] bus_address,
   output wire strap_valid
);
   // ==========================================================
   // states
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_AACK = 3'd2;
   localparam ST_RXB = 3'd3;
   localparam ST_RACK = 3'd4;
   localparam ST_TXB = 3'd5;
   localparam ST_TACK = 3'd6;
   // ==========================================================
   // pins: 20 MHz sampling covers a 1 MHz bus with margin
   wire scl_s;
   wire sda_s;
   wire en_s;
   input_sync3 #(.RST_VAL(1'b1)) u_scl (.clock(clock), .rst_b(rst_b),
      .din(scl_in), .dout(scl_s));
   input_sync3 #(.RST_VAL(1'b1)) u_sda (.clock(clock), .rst_b(rst_b),
      .din(sda_in), .dout(sda_s));
   input_sync3 #(.RST_VAL(1'b0)) u_en (.clock(clock), .rst_b(rst_b),
      .din(enable_pin), .dout(en_s));
   // supply monitor is asynchronous to this clock, so it is synced too
   wire bias_s;
   input_sync3 #(.RST_VAL(1'b0)) u_bias (.clock(clock), .rst_b(rst_b),
      .din(bias_good), .dout(bias_s));
   wire [3:0] addr_bits;
   strap_decoder u_strap (.clock(clock), .rst_b(rst_b),
      .bias_good(bias_s), .strap_level(strap_level),
      .addr_bits(addr_bits),
      .forced_continuous_conduction(forced_continuous_conduction),
      .strap_valid(strap_valid));
   assign bus_address = {`ADDR_FIXED_HI, addr_bits};
   // ==========================================================
   // bus events
   reg scl_d_ff;
   reg sda_d_ff;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_ff;
   wire scl_fall = ~scl_s & scl_d_ff;
   wire start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   wire stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   // ==========================================================
   // registers
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] shift_ff;
   reg [7:0] nxt_shift;
   reg [2:0] bit_ff;
   reg [2:0] nxt_bit;
   reg [7:0] pointer_ff;
   reg [7:0] nxt_pointer;
   reg byte_idx_ff; // 0: pointer byte next, 1: data byte next
   reg nxt_byte_idx;
   reg rd_ff;
   reg nxt_rd;
   reg sda_drv_ff;
   reg nxt_sda_drv;
   reg [7:0] run_control_ff;
   reg [7:0] nxt_run_control;
   reg [7:0] turn_on_source_config_ff;
   reg [7:0] nxt_turn_on_source_config;
   reg nv_loaded_ff;
   assign sda_out = 1'b0;
   assign sda_oe = sda_drv_ff;
   function [7:0] reg_read;
      input [7:0] ptr;
      input [7:0] rc;
      input [7:0] ts;
      begin
         case (ptr)
            `CMD_RUN_CONTROL: reg_read = rc;
            `CMD_TURN_ON_SRC: reg_read = ts;
            default: reg_read = 8'h00;
         endcase
      end
   endfunction
   wire shift_ff_is_run = (pointer_ff == `CMD_RUN_CONTROL);
   wire shift_ff_is_src = (pointer_ff == `CMD_TURN_ON_SRC);
   // ==========================================================
   // byte engine
   always @* begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_bit = bit_ff;
      nxt_pointer = pointer_ff;
      nxt_byte_idx = byte_idx_ff;
      nxt_rd = rd_ff;
      nxt_sda_drv = sda_drv_ff;
      nxt_run_control = run_control_ff;
      nxt_turn_on_source_config = turn_on_source_config_ff;
      if (stop_ev) begin
         // pointer is left alone so a later read finds it
         nxt_state = ST_IDLE;
         nxt_sda_drv = 1'b0;
      end else if (start_ev) begin
         // repeated start or fresh start both land here
         nxt_state = ST_ADDR;
         nxt_bit = 3'd7;
         nxt_sda_drv = 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_sda_drv = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], sda_s};
                  if (bit_ff == 3'd0) begin
                     nxt_state = ST_AACK;
                  end else begin
                     nxt_bit = bit_ff - 3'd1;
                  end
               end
            end
            ST_AACK: begin
               // seven-bit match only; no ten-bit prefix
               if (scl_fall) begin
                  if (shift_ff[7:1] == bus_address && strap_valid) begin
                     nxt_sda_drv = 1'b1;
                     nxt_rd = shift_ff[0];
                     nxt_byte_idx = 1'b0;
                  end else begin
                     nxt_state = ST_IDLE;
                  end
               end else if (scl_rise && sda_drv_ff) begin
                  nxt_bit = 3'd7;
                  nxt_state = rd_ff ? ST_TXB : ST_RXB;
                  nxt_shift = reg_read(pointer_ff, run_control_ff,
                     turn_on_source_config_ff);
               end
            end
            ST_RXB: begin
               if (scl_fall) begin
                  nxt_sda_drv = 1'b0;
               end
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], sda_s};
                  if (bit_ff == 3'd0) begin
                     nxt_state = ST_RACK;
                  end else begin
                     nxt_bit = bit_ff - 3'd1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_fall && !sda_drv_ff) begin
                  nxt_sda_drv = 1'b1;
                  if (!byte_idx_ff) begin
                     nxt_pointer = shift_ff;
                     nxt_byte_idx = 1'b1;
                  end else if (shift_ff_is_run) begin
                     nxt_run_control = shift_ff;
                  end else if (shift_ff_is_src) begin
                     nxt_turn_on_source_config = shift_ff;
                  end
                  // other codes: acked, nothing stored
               end else if (scl_rise && sda_drv_ff) begin
                  nxt_bit = 3'd7;
                  nxt_state = ST_RXB;
               end
            end
            ST_TXB: begin
               if (scl_fall) begin
                  nxt_sda_drv = ~shift_ff[7];
               end
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], 1'b0};
                  if (bit_ff == 3'd0) begin
                     nxt_state = ST_TACK;
                  end else begin
                     nxt_bit = bit_ff - 3'd1;
                  end
               end
            end
            ST_TACK: begin
               if (scl_fall) begin
                  nxt_sda_drv = 1'b0;
               end
               if (scl_rise) begin
                  // host nack ends it; ack resends same byte
                  if (sda_s) begin
                     nxt_state = ST_IDLE;
                  end else begin
                     nxt_bit = 3'd7;
                     nxt_state = ST_TXB;
                     nxt_shift = reg_read(pointer_ff, run_control_ff,
                        turn_on_source_config_ff);
                  end
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_sda_drv = 1'b0;
            end
         endcase
      end
   end
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         shift_ff <= 8'h00;
         bit_ff <= 3'd7;
         pointer_ff <= 8'h00;
         byte_idx_ff <= 1'b0;
         rd_ff <= 1'b0;
         sda_drv_ff <= 1'b0;
         run_control_ff <= `RUN_CONTROL_RST;
         turn_on_source_config_ff <= `TURN_ON_SRC_RST;
         nv_loaded_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         bit_ff <= nxt_bit;
         pointer_ff <= nxt_pointer;
         byte_idx_ff <= nxt_byte_idx;
         rd_ff <= nxt_rd;
         sda_drv_ff <= nxt_sda_drv;
         run_control_ff <= nxt_run_control;
         nv_loaded_ff <= 1'b1;
         // stored copy stands in for nonvolatile recall
         if (!nv_loaded_ff) begin
            turn_on_source_config_ff <= TURN_ON_SRC_NV;
         end else begin
            turn_on_source_config_ff <= nxt_turn_on_source_config;
         end
      end
   end
   // ==========================================================
   // run decision
   reg cmd_on;
   reg [1:0] cmd_margin;
   reg cmd_ign;
   reg want_on;
   always @* begin
      cmd_on = 1'b0;
      cmd_margin = `MARGIN_NONE;
      cmd_ign = 1'b0;
      if ((run_control_ff & `RC_ON_MASK) == `RC_OFF_VAL) begin
         cmd_on = 1'b0;
      end else if ((run_control_ff & `RC_NOM_MASK) == `RC_NOM_VAL) begin
         cmd_on = 1'b1;
      end else begin
         case (run_control_ff)
            `RC_MLO_IGN: begin
               cmd_on = 1'b1;
               cmd_margin = `MARGIN_LOW;
               cmd_ign = 1'b1;
            end
            `RC_MLO_ACT: begin
               cmd_on = 1'b1;
               cmd_margin = `MARGIN_LOW;
            end
            `RC_MHI_IGN: begin
               cmd_on = 1'b1;
               cmd_margin = `MARGIN_HIGH;
               cmd_ign = 1'b1;
            end
            `RC_MHI_ACT: begin
               cmd_on = 1'b1;
               cmd_margin = `MARGIN_HIGH;
            end
            default: begin
               // unlisted pattern: follow the on bit, no margin
               cmd_on = run_control_ff[`RC_ON_BIT];
            end
         endcase
      end
      case (turn_on_source_config_ff)
         `TS_NONE: want_on = 1'b1;
         `TS_PIN: want_on = en_s;
         `TS_CMD: want_on = cmd_on;
         `TS_BOTH: want_on = cmd_on & en_s;
         default: want_on = cmd_on & en_s;
      endcase
   end
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         converter_on <= 1'b0;
         margin_sel <= `MARGIN_NONE;
         ignore_faults <= 1'b0;
      end else begin
         converter_on <= want_on & strap_valid;
         margin_sel <= cmd_margin;
         ignore_faults <= cmd_ign;
      end
   end
endmodule // pmbus_target_onoff_control
`default_nettype wire

// ==== src/pmbus_onoff_defs.vh ====
`ifndef PMBUS_ONOFF_DEFS_VH
`define PMBUS_ONOFF_DEFS_VH
// ==========================================================
// bus address and command codes
`define ADDR_FIXED_HI 3'b001
`define CMD_RUN_CONTROL 8'h01
`define CMD_TURN_ON_SRC 8'h02
// ==========================================================
// reset values
`define RUN_CONTROL_RST 8'h00
`define TURN_ON_SRC_RST 8'h1f
// ==========================================================
// run-control field layout and codes
`define RC_ON_BIT 7
`define RC_ON_MASK 8'hc3
`define RC_OFF_VAL 8'h00
`define RC_NOM_MASK 8'hf3
`define RC_NOM_VAL 8'h80
`define RC_MLO_IGN 8'h94
`define RC_MLO_ACT 8'h98
`define RC_MHI_IGN 8'ha4
`define RC_MHI_ACT 8'ha8
`define MARGIN_NONE 2'b00
`define MARGIN_LOW 2'b01
`define MARGIN_HIGH 2'b10
// ==========================================================
// turn-on source codes
`define TS_NONE 8'h13
`define TS_PIN 8'h17
`define TS_CMD 8'h1b
`define TS_BOTH 8'h1f
// ==========================================================
// strap decode
`define STRAP_OPEN 5'h1f
`define STRAP_LEVELS 32
`define STRAP_ADDR_RST 4'hf
`define STRAP_FCC_RST 1'b1
`endif

// ==== src/input_sync3.v ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// three flop sync; output moves when stages two and three agree
module input_sync3 #(
   parameter RST_VAL = 1'b1
) (
   input wire clock,
   input wire rst_b,
   input wire din,
   output reg dout
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            dout <= s3_ff;
         end
      end
   end
endmodule // input_sync3
`default_nettype wire

// ==== src/strap_decoder.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_onoff_defs.vh"
// ==========================================================
// captures strap level once bias supply is good
module strap_decoder (
   input wire clock,
   input wire rst_b,
   input wire bias_good,
   input wire [4:0] strap_level,
   output reg [3:0] addr_bits,
   output reg forced_continuous_conduction,
   output reg strap_valid
);
   // level 31 (open) -> 1111 fcc; level 0 (short) -> 0000 skip
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         addr_bits <= `STRAP_ADDR_RST;
         forced_continuous_conduction <= `STRAP_FCC_RST;
         strap_valid <= 1'b0;
      end else if (!bias_good) begin
         strap_valid <= 1'b0;
      end else if (!strap_valid) begin
         addr_bits <= strap_level[4:1];
         forced_continuous_conduction <= strap_level[0];
         strap_valid <= 1'b1;
      end
   end
endmodule // strap_decoder
`default_nettype wire

// ==== tb/pmbus_onoff_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======
// port checks of the bus target
module pmbus_onoff_props (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic enable_pin,
   input wire logic bias_good,
   input wire logic [4:0] strap_level,
   input wire logic converter_on,
   input wire logic [1:0] margin_sel,
   input wire logic ignore_faults,
   input wire logic forced_continuous_conduction,
   input wire logic [6:0] bus_address,
   input wire logic strap_valid
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   // data may only move while the clock line is low
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda changed with scl high");
   a_no_early_ack: assert property (!strap_valid |-> !sda_oe)
      else $error("ack before strap captured");
   a_strap_wait: assert property (!strap_valid && !bias_good |=> !strap_valid)
      else $error("strap captured without supply");
   a_addr_map: assert property (strap_valid |-> bus_address ==
      {3'b001, strap_level[4:1]} &&
      forced_continuous_conduction == strap_level[0])
      else $error("address decode wrong");
   a_ign_margin: assert property (ignore_faults |-> margin_sel != 2'b00)
      else $error("ignore faults without margin");
   a_margin_on: assert property (margin_sel != 2'b00 |-> converter_on)
      else $error("margin while off");
   a_reset_vals: assert property ($rose(rst_b) |-> !converter_on &&
      !sda_oe && !strap_valid && margin_sel == 2'b00)
      else $error("reset values wrong");
endmodule // pmbus_onoff_props
`default_nettype wire

// ==== tb/pmbus_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======
// bus controller; every line level is held 6 clocks (18 per bit), longer than sync delay
module pmbus_host_model (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   output logic got,
   output logic [7:0] got_val
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      got = 1'b0;
      got_val = 8'h00;
   end
   task automatic hold();
      repeat (6) @(negedge clock);
   endtask
   // serves for start and repeated start alike
   task automatic start();
      sda_low = 1'b0;
      hold();
      scl = 1'b1;
      hold();
      sda_low = 1'b1;
      hold();
      scl = 1'b0;
      hold();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      hold();
      scl = 1'b1;
      hold();
      sda_low = 1'b0;
      hold();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      hold();
      scl = 1'b1;
      hold();
      r = sda;
      scl = 1'b0;
      hold();
   endtask
   task automatic post(input logic [7:0] v);
      got_val = v;
      got = 1'b1;
      @(negedge clock);
      got = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      post({7'h00, !r});
   endtask
   task automatic rbyte(input logic last);
      logic [7:0] d;
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
      post(d);
   endtask
endmodule // pmbus_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock, rst_b, enable_pin, bias_good;
   logic [4:0] strap_level;
   logic [31:0] seed;
   logic [6:0] adr;
   logic [7:0] v;
   logic [7:0] exp_q[$];
   logic [7:0] rcv[8] = '{8'h00, 8'h3c, 8'h80, 8'h8c,
      8'h94, 8'h98, 8'ha4, 8'ha8};
   logic [7:0] tsv[4] = '{8'h13, 8'h17, 8'h1b, 8'h1f};
   int n_mismatch = 0, num_checks = 0, cycles = 0;
   wire scl, sda_low, got, sda_out, sda_oe, converter_on, ignore_faults;
   wire fcc, strap_valid;
   wire [7:0] got_val;
   wire [1:0] margin_sel;
   wire [6:0] bus_address;
   wire sda = !(sda_low || sda_oe);
   pmbus_target_onoff_control uut (.clock(clock), .rst_b(rst_b),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .enable_pin(enable_pin), .bias_good(bias_good),
      .strap_level(strap_level), .converter_on(converter_on),
      .margin_sel(margin_sel), .ignore_faults(ignore_faults),
      .forced_continuous_conduction(fcc), .bus_address(bus_address),
      .strap_valid(strap_valid));
   pmbus_host_model host (.clock(clock), .sda(sda), .scl(scl),
      .sda_low(sda_low), .got(got), .got_val(got_val));
   initial clock = 1'b0;
   always #25 clock = !clock;
   // ======
   // checking and closing
   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock) begin
      if (got === 1'b1) check(got_val, exp_q.pop_front());
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // ======
   // bus transfers; xfer sends one data byte when n > 0, rd reads n data bytes
   task xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
      input int n, input logic ok);
      exp_q.push_back({7'h00, ok});
      host.start();
      host.wbyte({a, 1'b0});
      if (ok) begin
         exp_q.push_back(8'h01);
         host.wbyte(p);
         if (n > 0) begin
            exp_q.push_back(8'h01);
            host.wbyte(d);
         end
      end
      host.stop();
   endtask
   task rd(input logic [7:0] p, input logic [7:0] e, input logic sr,
      input int n);
      if (sr) begin
         exp_q.push_back(8'h01);
         exp_q.push_back(8'h01);
         host.start();
         host.wbyte({adr, 1'b0});
         host.wbyte(p);
      end
      exp_q.push_back(8'h01);
      host.start();
      host.wbyte({adr, 1'b1});
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(e);
         host.rbyte(i == n - 1);
      end
      host.stop();
   endtask
   // ======
   // main sequence
   initial begin
      rst_b = 1'b0;
      enable_pin = 1'b1;
      bias_good = 1'b0;
      seed = 32'h203d;
      strap_level = $random(seed);
      adr = {3'b001, strap_level[4:1]};
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (20) @(negedge clock);
      xfer(adr, 8'h01, 8'h80, 1, 1'b0);
      bias_good = 1'b1;
      repeat (20) @(negedge clock);
      check({1'b0, bus_address}, {1'b0, adr});
      check({7'h00, fcc}, {7'h00, strap_level[0]});
      foreach (rcv[i]) begin
         xfer(adr, 8'h01, rcv[i], 1, 1'b1);
         repeat (20) @(negedge clock);
         check({7'h00, converter_on}, {7'h00, rcv[i][7]});
         if (rcv[i][7]) begin
            check({6'h00, margin_sel}, {6'h00, rcv[i][5:4]});
            check({7'h00, ignore_faults},
               {7'h00, rcv[i][2] && rcv[i][5:4] != 2'b00});
         end
         rd(8'h01, rcv[i], 1'b1, 1);
      end
      xfer(adr, 8'h01, 8'h80, 1, 1'b1);
      for (int e = 0; e < 2; e++) begin
         foreach (tsv[i]) begin
            enable_pin = e[0];
            xfer(adr, 8'h02, tsv[i], 1, 1'b1);
            repeat (20) @(negedge clock);
            check({7'h00, converter_on},
               {7'h00, tsv[i][2] ? e[0] : 1'b1});
            rd(8'h02, tsv[i], 1'b1, 1);
         end
      end
      xfer(adr, 8'h01, 8'h00, 0, 1'b1);
      xfer(adr ^ 7'h01, 8'h01, 8'h00, 1, 1'b0);
      rd(8'h01, 8'h80, 1'b0, 2);
      xfer(adr, 8'h05, 8'hff, 1, 1'b1);
      rd(8'h05, 8'h00, 1'b1, 1);
      rd(8'h01, 8'h80, 1'b1, 2);
      check({7'h00, converter_on}, 8'h01);
      v = $random(seed);
      xfer(adr, 8'h01, v, 1, 1'b1);
      rd(8'h01, v, 1'b1, 1);
      repeat (10) @(negedge clock);
      end_sim();
   end
endmodule // testbench
bind pmbus_target_onoff_control pmbus_onoff_props chk (.clock(clock),
   .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .enable_pin(enable_pin), .bias_good(bias_good),
   .strap_level(strap_level), .converter_on(converter_on),
   .margin_sel(margin_sel), .ignore_faults(ignore_faults),
   .forced_continuous_conduction(forced_continuous_conduction),
   .bus_address(bus_address), .strap_valid(strap_valid));
`default_nettype wire
